// ### addr_window.sv
`timescale 1ns/1ns
// Single address window match, shared by each decode of the fabric.
module addr_window #(
    parameter logic [23:0] BASE = 24'h000000,
    parameter logic [23:0] WORDS = 24'h000100
) (
    input wire logic [23:0] addr,
    output logic hit,
    output logic [23:0] offset
);
    assign offset = addr - BASE;
    assign hit = (addr >= BASE) && (offset < WORDS);
endmodule

// ### core_memory_bus_fabric.sv
`timescale 1ns/1ns
// Function
// - Program port: 21-bit address, 16-bit read.
// - Program writes use low 16 write bits.
// - Primary reads return up to 32 bits.
// - Primary bus handles byte, word, long accesses.
// - Primary bus also decodes memory-mapped I/O.
// - Secondary: 24-bit word address, 16-bit read.
// - Secondary path only reads, with primary access.
// - Peripheral bus 16-bit, no added wait.
// - Peripheral writes from core, reads to primary.
// - Primary RAM 32 bits, others 16 bits.
// - Flash control via peripheral bus, array direct.
// - Byte accesses force address MSB zero.
module core_memory_bus_fabric #(
    parameter logic [23:0] RAM_BASE = fabric_pkg::RAM_BASE,
    parameter logic [23:0] RAM_WORDS = fabric_pkg::RAM_WORDS,
    parameter logic [23:0] FLASH_BASE = fabric_pkg::FLASH_BASE,
    parameter logic [23:0] FLASH_WORDS = fabric_pkg::FLASH_WORDS,
    parameter logic [23:0] PERIPH_BASE = fabric_pkg::PERIPH_BASE,
    parameter logic [23:0] PERIPH_WORDS = fabric_pkg::PERIPH_WORDS,
    parameter logic [23:0] MMIO_BASE = fabric_pkg::MMIO_BASE,
    parameter logic [23:0] MMIO_WORDS = fabric_pkg::MMIO_WORDS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Core side.
    input wire fabric_pkg::prog_req_s prog_req,
    input wire fabric_pkg::data_req_s data_req,
    input wire fabric_pkg::sec_req_s sec_req,
    output logic [15:0] prog_rdata,
    output logic [31:0] primary_read_bus,
    output logic [15:0] secondary_read_bus,
    output logic sec_refused,
    // Program memory.
    output fabric_pkg::prog_req_s pmem_req,
    input wire logic [15:0] pmem_rdata,
    // Primary data RAM, 32-bit port, plus byte lane enables.
    output fabric_pkg::data_req_s ram_req,
    output logic [3:0] ram_be,
    input wire logic [31:0] ram_rdata,
    // Secondary RAM read port, 16 bits.
    output logic ram2_rd,
    output logic [23:0] ram2_addr,
    input wire logic [15:0] ram2_rdata,
    // Data flash array, 16 bits.
    output fabric_pkg::periph_req_s dflash_req,
    input wire logic [15:0] dflash_rdata,
    // Peripheral register bus (flash controller registers live here).
    output fabric_pkg::periph_req_s peripheral_reg_bus,
    input wire logic [15:0] periph_rdata,
    // Memory-mapped I/O, 16 bits.
    output fabric_pkg::periph_req_s mmio_req,
    input wire logic [15:0] mmio_rdata
);

    // -------------------------------------------------------------------
    // Primary address conditioning
    // -------------------------------------------------------------------
    wire logic is_byte;
    wire logic [23:0] primary_data_addr;
    wire logic [31:0] wdata;
    assign is_byte = (data_req.size == fabric_pkg::SIZE_BYTE);
    // Byte addresses only reach the lower half of the space.
    assign primary_data_addr = is_byte ? {1'b0, data_req.addr[fabric_pkg::ADDR_MSB-1:0]}
                                       : data_req.addr;
    assign wdata = data_req.wdata;

    // -------------------------------------------------------------------
    // Decode
    // -------------------------------------------------------------------
    wire logic hit_ram;
    wire logic hit_flash;
    wire logic hit_periph;
    wire logic hit_mmio;
    wire logic [23:0] off_ram;
    wire logic [23:0] off_flash;
    wire logic [23:0] off_periph;
    wire logic [23:0] off_mmio;
    wire logic [23:0] sec_off;
    wire logic sec_hit;

    addr_window #(.BASE(RAM_BASE), .WORDS(RAM_WORDS)) u_ram (
        .addr(primary_data_addr), .hit(hit_ram), .offset(off_ram));
    addr_window #(.BASE(FLASH_BASE), .WORDS(FLASH_WORDS)) u_flash (
        .addr(primary_data_addr), .hit(hit_flash), .offset(off_flash));
    addr_window #(.BASE(PERIPH_BASE), .WORDS(PERIPH_WORDS)) u_periph (
        .addr(primary_data_addr), .hit(hit_periph), .offset(off_periph));
    addr_window #(.BASE(MMIO_BASE), .WORDS(MMIO_WORDS)) u_mmio (
        .addr(primary_data_addr), .hit(hit_mmio), .offset(off_mmio));
    addr_window #(.BASE(RAM_BASE), .WORDS(RAM_WORDS)) u_sec (
        .addr(sec_req.addr), .hit(sec_hit), .offset(sec_off));

    wire logic access;
    wire fabric_pkg::target_e target;
    assign access = data_req.rd | data_req.wr;
    // I/O windows take priority so a register block may shadow memory.
    assign target = !access ? fabric_pkg::TGT_NONE :
                    hit_mmio ? fabric_pkg::TGT_MMIO :
                    hit_periph ? fabric_pkg::TGT_PERIPH :
                    hit_ram ? fabric_pkg::TGT_RAM :
                    hit_flash ? fabric_pkg::TGT_FLASH :
                    fabric_pkg::TGT_NONE;

    // Byte lane enables for the 32-bit RAM port.
    function automatic logic [3:0] lanes(input fabric_pkg::access_size_e sz, input logic [1:0] a);
        case (sz)
            fabric_pkg::SIZE_BYTE: lanes = 4'h1 << a;
            fabric_pkg::SIZE_WORD: lanes = a[1] ? 4'hC : 4'h3;
            default: lanes = 4'hF;
        endcase
    endfunction

    // -------------------------------------------------------------------
    // Request fan-out (combinational, same cycle as the address phase)
    // -------------------------------------------------------------------
    assign pmem_req = '{rd: prog_req.rd, wr: prog_req.wr, addr: prog_req.addr,
                        wdata: wdata[15:0]};
    assign ram_req = '{rd: data_req.rd && target == fabric_pkg::TGT_RAM,
                       wr: data_req.wr && target == fabric_pkg::TGT_RAM,
                       size: data_req.size, addr: off_ram,
                       wdata: wdata};
    assign ram_be = lanes(data_req.size, off_ram[1:0]);
    assign dflash_req = '{sel: target == fabric_pkg::TGT_FLASH,
                          rd: data_req.rd, wr: data_req.wr,
                          addr: off_flash[15:0], wdata: wdata[15:0]};
    assign peripheral_reg_bus = '{sel: target == fabric_pkg::TGT_PERIPH,
                                  rd: data_req.rd, wr: data_req.wr,
                                  addr: off_periph[15:0], wdata: wdata[15:0]};
    assign mmio_req = '{sel: target == fabric_pkg::TGT_MMIO,
                        rd: data_req.rd, wr: data_req.wr,
                        addr: off_mmio[15:0], wdata: wdata[15:0]};

    // The secondary path only serves a read paired with a primary access.
    wire logic sec_ok;
    assign sec_ok = sec_req.rd && access && sec_hit;
    assign ram2_rd = sec_ok;
    assign ram2_addr = sec_off;

    // -------------------------------------------------------------------
    // Data phase: one clock after the address phase
    // -------------------------------------------------------------------
    fabric_pkg::target_e target_q;
    logic prd_q;
    logic drd_q;
    logic sec_ok_q;
    logic sec_bad_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            target_q <= fabric_pkg::TGT_NONE;
            prd_q <= 1'b0;
            drd_q <= 1'b0;
            sec_ok_q <= 1'b0;
            sec_bad_q <= 1'b0;
        end else if (ce) begin
            target_q <= target;
            prd_q <= prog_req.rd;
            drd_q <= data_req.rd;
            sec_ok_q <= sec_ok;
            sec_bad_q <= sec_req.rd && !sec_ok;
        end
    end

    // Read mux; narrow targets land in the low half with the upper half zero.
    wire logic [31:0] next_primary;
    assign next_primary = !drd_q ? fabric_pkg::READ_IDLE :
        (target_q == fabric_pkg::TGT_RAM) ? ram_rdata :
        (target_q == fabric_pkg::TGT_FLASH) ? {16'h0000, dflash_rdata} :
        (target_q == fabric_pkg::TGT_PERIPH) ? {16'h0000, periph_rdata} :
        (target_q == fabric_pkg::TGT_MMIO) ? {16'h0000, mmio_rdata} :
        fabric_pkg::READ_IDLE;

    // Read data is passed through in the data phase; no extra wait is added.
    assign primary_read_bus = next_primary;
    assign prog_rdata = prd_q ? pmem_rdata : 16'h0000;
    assign secondary_read_bus = sec_ok_q ? ram2_rdata : 16'h0000;
    assign sec_refused = sec_bad_q;

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    byte_msb_a: assert property (
        @(posedge clk) disable iff (rst)
        ram_req.wr && is_byte |-> !primary_data_addr[fabric_pkg::ADDR_MSB])
        else $error("byte access reached upper half");
    prog_wlow_a: assert property (
        @(posedge clk) disable iff (rst)
        prog_req.wr |-> pmem_req.wdata == data_req.wdata[15:0])
        else $error("program write data not low half");
    sec_only_a: assert property (
        @(posedge clk) disable iff (rst)
        ram2_rd |-> access && sec_req.rd)
        else $error("secondary read without primary access");
    periph_one_a: assert property (
        @(posedge clk) disable iff (rst)
        $onehot0({ram_req.rd | ram_req.wr, dflash_req.sel,
                  peripheral_reg_bus.sel, mmio_req.sel}))
        else $error("primary decode selected two targets");
    sequence periph_read_s;
        peripheral_reg_bus.sel && data_req.rd && ce;
    endsequence
    periph_rd_a: assert property (
        @(posedge clk) disable iff (rst)
        periph_read_s |=> primary_read_bus == {16'h0000, periph_rdata})
        else $error("peripheral read not on primary bus");
    ram_rd_a: assert property (
        @(posedge clk) disable iff (rst)
        ram_req.rd && ce |=> primary_read_bus == ram_rdata)
        else $error("ram read data lost");
    sec_rd_a: assert property (
        @(posedge clk) disable iff (rst)
        ram2_rd && ce |=> secondary_read_bus == ram2_rdata)
        else $error("secondary read data lost");
    prog_rd_a: assert property (
        @(posedge clk) disable iff (rst)
        prog_req.rd && ce |=> prog_rdata == pmem_rdata)
        else $error("program read data lost");
    long_be_a: assert property (
        @(posedge clk) disable iff (rst)
        ram_req.wr && data_req.size == fabric_pkg::SIZE_LONG |-> ram_be == 4'hF)
        else $error("long write lost lanes");
    word_hi_a: assert property (
        @(posedge clk) disable iff (rst)
        (ram_req.rd || ram_req.wr) && data_req.size == fabric_pkg::SIZE_WORD && off_ram[1]
        |-> ram_be == 4'hC)
        else $error("upper word lanes wrong");
    // An unmapped read must not leave stale data on the primary bus.
    idle_read_a: assert property (
        @(posedge clk) disable iff (rst)
        data_req.rd && target == fabric_pkg::TGT_NONE && ce
        |=> primary_read_bus == fabric_pkg::READ_IDLE)
        else $error("unmapped read returned data");
    ce_freeze_a: assert property (
        @(posedge clk) disable iff (rst)
        !ce |=> $stable(sec_refused))
        else $error("state moved while clock enable low");

endmodule

// ### fabric_pkg.sv
package fabric_pkg;

    // -------------------------------------------------------------------
    // Bus widths
    // -------------------------------------------------------------------
    localparam int PROG_ADDR_W = 21;
    localparam int PROG_DATA_W = 16;
    localparam int DATA_ADDR_W = 24;
    localparam int WIDE_DATA_W = 32;
    localparam int NARROW_DATA_W = 16;
    localparam int PERIPH_ADDR_W = 16;

    // -------------------------------------------------------------------
    // Primary data address decode
    // -------------------------------------------------------------------
    // Window bases and sizes are parameters of the fabric; these are defaults.
    localparam logic [23:0] RAM_BASE = 24'h000000;
    localparam logic [23:0] RAM_WORDS = 24'h002000;
    localparam logic [23:0] FLASH_BASE = 24'h004000;
    localparam logic [23:0] FLASH_WORDS = 24'h001000;
    localparam logic [23:0] PERIPH_BASE = 24'h00F000;
    localparam logic [23:0] PERIPH_WORDS = 24'h001000;
    localparam logic [23:0] MMIO_BASE = 24'hFFFF00;
    localparam logic [23:0] MMIO_WORDS = 24'h000100;
    localparam int ADDR_MSB = 23;
    localparam logic [31:0] READ_IDLE = 32'h00000000;

    // Access size on the primary data path.
    typedef enum logic [1:0] {
        SIZE_BYTE = 2'h0,
        SIZE_WORD = 2'h1,
        SIZE_LONG = 2'h2
    } access_size_e;

    // Target selected by the primary decode, one-hot.
    typedef enum logic [4:0] {
        TGT_NONE = 5'h01,
        TGT_RAM = 5'h02,
        TGT_FLASH = 5'h04,
        TGT_PERIPH = 5'h08,
        TGT_MMIO = 5'h10
    } target_e;

    // -------------------------------------------------------------------
    // Carriers
    // -------------------------------------------------------------------
    typedef struct packed {
        logic rd;
        logic wr;
        logic [20:0] addr;
        logic [15:0] wdata;
    } prog_req_s;

    typedef struct packed {
        logic rd;
        logic wr;
        access_size_e size;
        logic [23:0] addr;
        logic [31:0] wdata;
    } data_req_s;

    typedef struct packed {
        logic rd;
        logic [23:0] addr;
    } sec_req_s;

    typedef struct packed {
        logic sel;
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } periph_req_s;

endpackage

// ### mem_model.sv
`timescale 1ns/1ns
// -----------------------------------------------------------------------
// Memories and registers behind the fabric
// -----------------------------------------------------------------------
// Read data follows the address one edge later. The pattern changes with
// the address, bits 15:0 only on the program and secondary ports, so stale data from an access differing there never looks right.
module mem_model (
    input wire logic clk,
    input wire fabric_pkg::prog_req_s pmem_req,
    input wire fabric_pkg::data_req_s ram_req,
    input wire logic [23:0] ram2_addr,
    input wire fabric_pkg::periph_req_s dflash_req,
    input wire fabric_pkg::periph_req_s peripheral_reg_bus,
    input wire fabric_pkg::periph_req_s mmio_req,
    output logic [15:0] pmem_rdata,
    output logic [31:0] ram_rdata,
    output logic [15:0] ram2_rdata,
    output logic [15:0] dflash_rdata,
    output logic [15:0] periph_rdata,
    output logic [15:0] mmio_rdata
);
    always_ff @(posedge clk) begin
        pmem_rdata <= pmem_req.addr[15:0] ^ 16'h5A5A;
        ram_rdata <= {8'hC3, ram_req.addr};
        ram2_rdata <= ram2_addr[15:0] ^ 16'h3C3C;
        dflash_rdata <= dflash_req.addr ^ 16'h1111;
        periph_rdata <= peripheral_reg_bus.addr ^ 16'h2222;
        mmio_rdata <= mmio_req.addr ^ 16'h4444;
    end
endmodule

// ### tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    fabric_pkg::prog_req_s prog_req = '0;
    fabric_pkg::data_req_s data_req = '0;
    fabric_pkg::sec_req_s sec_req = '0;
    fabric_pkg::prog_req_s pmem_req;
    fabric_pkg::data_req_s ram_req;
    fabric_pkg::periph_req_s dflash_req, peripheral_reg_bus, mmio_req;
    logic [15:0] prog_rdata, secondary_read_bus, pmem_rdata, ram2_rdata;
    logic [15:0] dflash_rdata, periph_rdata, mmio_rdata;
    logic [31:0] primary_read_bus, ram_rdata;
    logic [23:0] ram2_addr;
    logic [3:0] ram_be;
    logic sec_refused, ram2_rd;
    int failures = 0;
    int compares = 0;

    core_memory_bus_fabric dut (.clk(clk), .rst(rst), .ce(ce), .prog_req(prog_req),
        .data_req(data_req), .sec_req(sec_req),
        .prog_rdata(prog_rdata), .primary_read_bus(primary_read_bus),
        .secondary_read_bus(secondary_read_bus), .sec_refused(sec_refused),
        .pmem_req(pmem_req), .pmem_rdata(pmem_rdata), .ram_req(ram_req), .ram_be(ram_be),
        .ram_rdata(ram_rdata), .ram2_rd(ram2_rd), .ram2_addr(ram2_addr),
        .ram2_rdata(ram2_rdata), .dflash_req(dflash_req), .dflash_rdata(dflash_rdata),
        .peripheral_reg_bus(peripheral_reg_bus), .periph_rdata(periph_rdata),
        .mmio_req(mmio_req), .mmio_rdata(mmio_rdata));

    mem_model mem (.clk(clk), .pmem_req(pmem_req), .ram_req(ram_req), .ram2_addr(ram2_addr),
        .dflash_req(dflash_req), .peripheral_reg_bus(peripheral_reg_bus),
        .mmio_req(mmio_req), .pmem_rdata(pmem_rdata), .ram_rdata(ram_rdata),
        .ram2_rdata(ram2_rdata), .dflash_rdata(dflash_rdata),
        .periph_rdata(periph_rdata), .mmio_rdata(mmio_rdata));

    // -------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic fabric_pkg::data_req_s dreq(input logic rd, input logic wr,
        input fabric_pkg::access_size_e size, input logic [23:0] addr, input logic [31:0] wd);
        return '{rd: rd, wr: wr, size: size, addr: addr, wdata: wd};
    endfunction

    // Inputs change at the falling edge; the outputs settle before any check.
    task automatic drive(input fabric_pkg::prog_req_s p, input fabric_pkg::data_req_s d,
        input fabric_pkg::sec_req_s s);
        @(negedge clk);
        prog_req = p;
        data_req = d;
        sec_req = s;
        #1;
    endtask

    // Returns in the data phase, before the next request is driven.
    task automatic phase;
        @(posedge clk);
        @(negedge clk);
    endtask

    // -------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------
    task automatic prog_access;
        drive('{rd: 1'b1, wr: 1'b0, addr: 21'h1ABCD, wdata: 16'h0}, '0, '0);
        chk("pmem_addr", 32'h1ABCD, 32'(pmem_req.addr));
        phase();
        chk("prog_rdata", 32'hF197, 32'(prog_rdata));
        drive('{rd: 1'b0, wr: 1'b1, addr: 21'h10, wdata: 16'h0},
            dreq(1'b0, 1'b0, fabric_pkg::SIZE_WORD, 24'h0, 32'hDEADBEEF), '0);
        chk("pmem_wr", 32'h1, 32'(pmem_req.wr));
        chk("pmem_wdata", 32'hBEEF, 32'(pmem_req.wdata));
    endtask

    task automatic ram_access;
        int i;
        drive('0, dreq(1'b0, 1'b1, fabric_pkg::SIZE_LONG, 24'h000104, 32'h12345678), '0);
        chk("ram_wdata", 32'h12345678, ram_req.wdata);
        chk("ram_be_long", 32'hF, 32'(ram_be));
        drive('0, dreq(1'b1, 1'b0, fabric_pkg::SIZE_LONG, 24'h000100, 32'h0), '0);
        phase();
        chk("ram_long_read", 32'hC3000100, primary_read_bus);
        for (i = 0; i < 4; i++) begin
            drive('0, dreq(1'b1, 1'b0, fabric_pkg::SIZE_BYTE, 24'h800010 + 24'(i), 32'h0), '0);
            chk("ram_be_byte", 32'(4'h1 << i), 32'(ram_be));
            chk("byte_addr", 32'h10 + 32'(i), 32'(ram_req.addr));
        end
        drive('0, dreq(1'b1, 1'b0, fabric_pkg::SIZE_WORD, 24'h000020, 32'h0), '0);
        chk("ram_be_word", 32'h3, 32'(ram_be));
        drive('0, dreq(1'b1, 1'b0, fabric_pkg::SIZE_WORD, 24'h000022, 32'h0), '0);
        chk("ram_be_word_hi", 32'hC, 32'(ram_be));
        drive('0, dreq(1'b0, 1'b1, fabric_pkg::SIZE_BYTE, 24'h800013, 32'h000000AB), '0);
        chk("ram_wr_byte", 32'h1, 32'(ram_req.wr));
        chk("ram_be_byte_wr", 32'h8, 32'(ram_be));
        chk("ram_addr_byte_wr", 32'h13, 32'(ram_req.addr));
    endtask

    task automatic narrow_targets;
        drive('0, dreq(1'b1, 1'b0, fabric_pkg::SIZE_WORD, 24'hFFFF10, 32'h0), '0);
        chk("mmio_sel", 32'h1, 32'(mmio_req.sel));
        phase();
        chk("mmio_read", 32'h4454, primary_read_bus);
        drive('0, dreq(1'b0, 1'b1, fabric_pkg::SIZE_WORD, 24'h00F020, 32'h00001234), '0);
        chk("periph_wr", 32'h1, 32'(peripheral_reg_bus.wr));
        chk("periph_wdata", 32'h1234, 32'(peripheral_reg_bus.wdata));
        drive('0, dreq(1'b1, 1'b0, fabric_pkg::SIZE_WORD, 24'h00F020, 32'h0), '0);
        phase();
        chk("periph_read", 32'h2202, primary_read_bus);
        drive('0, dreq(1'b1, 1'b0, fabric_pkg::SIZE_WORD, 24'h004008, 32'h0), '0);
        chk("dflash_sel", 32'h1, 32'(dflash_req.sel));
        phase();
        chk("dflash_read", 32'h1119, primary_read_bus);
        drive('0, dreq(1'b1, 1'b0, fabric_pkg::SIZE_WORD, 24'h008000, 32'h0), '0);
        chk("unmapped_sel", 32'h0, 32'({ram_req.rd, dflash_req.sel, mmio_req.sel}));
        chk("unmapped_periph", 32'h0, 32'(peripheral_reg_bus.sel));
        phase();
        chk("unmapped_read", 32'h0, primary_read_bus);
    endtask

    // With the enable low the data phase must hold its selection.
    task automatic ce_hold;
        drive('0, dreq(1'b1, 1'b0, fabric_pkg::SIZE_LONG, 24'h000300, 32'h0), '0);
        phase();
        chk("ce_run_read", 32'hC3000300, primary_read_bus);
        @(negedge clk);
        ce = 1'b0;
        data_req = '0;
        #1;
        phase();
        chk("ce_hold_read", 32'hC3000000, primary_read_bus);
        @(negedge clk);
        ce = 1'b1;
        #1;
        phase();
        chk("ce_idle_read", 32'h0, primary_read_bus);
    endtask

    task automatic mid_reset;
        drive('{rd: 1'b1, wr: 1'b0, addr: 21'h00123, wdata: 16'h0},
            dreq(1'b1, 1'b0, fabric_pkg::SIZE_LONG, 24'h000200, 32'h0), '0);
        phase();
        chk("pre_reset_read", 32'hC3000200, primary_read_bus);
        @(negedge clk);
        rst = 1'b1;
        #1;
        chk("reset_primary", 32'h0, primary_read_bus);
        chk("reset_prog", 32'h0, 32'(prog_rdata));
        repeat (2) @(negedge clk);
        rst = 1'b0;
        #1;
        chk("release_read", 32'h0, primary_read_bus);
        phase();
        chk("first_read", 32'hC3000200, primary_read_bus);
        chk("first_prog", 32'h5B79, 32'(prog_rdata));
    endtask

    task automatic dual_read;
        drive('0, dreq(1'b1, 1'b0, fabric_pkg::SIZE_WORD, 24'h000040, 32'h0),
            '{rd: 1'b1, addr: 24'h000200});
        chk("ram2_rd", 32'h1, 32'(ram2_rd));
        chk("ram2_addr", 32'h200, 32'(ram2_addr));
        phase();
        chk("sec_read", 32'h3E3C, 32'(secondary_read_bus));
        chk("sec_ok", 32'h0, 32'(sec_refused));
        drive('0, '0, '{rd: 1'b1, addr: 24'h000200});
        chk("ram2_idle", 32'h0, 32'(ram2_rd));
        phase();
        chk("sec_refused", 32'h1, 32'(sec_refused));
    endtask

    task automatic summarize;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        forever #2 clk = ~clk;
    end

    initial begin
        #20000;
        failures++;
        summarize();
    end

    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        #1;
        chk("reset_read", 32'h0, primary_read_bus);
        prog_access();
        ram_access();
        narrow_targets();
        dual_read();
        ce_hold();
        mid_reset();
        summarize();
    end
endmodule
